// >>> hw/qpp_pkg.sv
// constants for the quad-lane pin, pause and protect front end of a serial flash
// shared by the pin front end and its lane shifter
package qpp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned BYTE_W = 8;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_QUAD = 2'h2;
    localparam logic PROT_UPPER_NEEDED = 1'h0;
    localparam logic PROT_LOWER_NEEDED = 1'h1;
    localparam logic [7:0] FRAME_IDLE = 8'h00;
    localparam logic [3:0] LANE_OE_NONE = 4'h0;
endpackage

// >>> hw/qpp_shift.sv
// link-side shifter on the serial clock: rising edge samples, falling edge launches
// assumes the frame clock stops outside frames; frame state is cleared by chip select
`timescale 1ns/100ps
module qpp_shift #(
    parameter int unsigned DATA_W = qpp_pkg::BYTE_W
) (
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic paused_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] lane_in_i,
    input wire logic [DATA_W-1:0] tx_data_i,
    output logic [DATA_W-1:0] rx_data_o,
    output logic rx_tog_o,
    output logic [3:0] lane_out_o,
    output logic [2:0] bit_cnt_o
);
    logic [DATA_W-1:0] rx_sh;
    logic [2:0] cnt;
    logic [DATA_W-1:0] tx_sh;
    logic [2:0] tx_cnt;
    logic [DATA_W-1:0] tx_src;
    logic [2:0] tx_last;
    // first launch of a byte must come from the new word, not the stale shifter
    always_comb begin
        tx_src = (tx_cnt == 3'h0) ? tx_data_i : tx_sh;
        case (mode_i)
            qpp_pkg::MODE_DUAL: tx_last = 3'h3;
            qpp_pkg::MODE_QUAD: tx_last = 3'h1;
            default: tx_last = 3'h7;
        endcase
    end
    // async clear by chip select: clock may stop before the frame ends
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rx_sh <= '0;
            cnt <= 3'h0;
            rx_tog_o <= 1'b0;
            rx_data_o <= '0;
        end else if (!paused_i) begin
            rx_sh <= {rx_sh[DATA_W-2:0], lane_in_i[0]};
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
                rx_data_o <= {rx_sh[DATA_W-2:0], lane_in_i[0]};
                rx_tog_o <= ~rx_tog_o;
            end
        end
    end
    assign bit_cnt_o = cnt;
    // counter held, not reset, across a pause
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            tx_sh <= '0;
            tx_cnt <= 3'h0;
            lane_out_o <= 4'h0;
        end else if (!paused_i) begin
            tx_cnt <= (tx_cnt == tx_last) ? 3'h0 : tx_cnt + 3'h1;
            case (mode_i)
                qpp_pkg::MODE_DUAL: lane_out_o <= {2'h0, tx_src[7:6]};
                qpp_pkg::MODE_QUAD: lane_out_o <= tx_src[7:4];
                default: lane_out_o <= {2'h0, tx_src[7], 1'b0};
            endcase
            case (mode_i)
                qpp_pkg::MODE_DUAL: tx_sh <= {tx_src[5:0], 2'h0};
                qpp_pkg::MODE_QUAD: tx_sh <= {tx_src[3:0], 4'h0};
                default: tx_sh <= {tx_src[6:0], 1'b0};
            endcase
        end
    end
endmodule // qpp_shift

// >>> hw/qpp_top.sv
// pin front end of a quad-capable serial flash: data lanes, protect and pause pins
// assumes the host drives chip select and serial clock; status bits come from core logic
// Overview of operation
// - data-out changes only on falling serial clock edges.
// - dual-output reads drive data-out and lane zero, two bits per falling edge.
// - data-out floats whenever chip select is high.
// - protect pin active only with lane enable 0 and protect bits 0,1.
// - with pin protection active and pin low, status writes are refused.
// - lane enable 1 makes protect pin quad lane two; host not protecting.
// - lane enable 0 makes lane three pin the pause input.
// - lane enable 1 makes pause pin quad lane three; host not pausing.
// - pause suspends a transfer without resetting its bit count.
// - pause starts on pause pin falling while serial clock low.
// - pause ends on pause pin rising while serial clock low.
// - commands, addresses and data sampled on rising serial clock edges.
// - after power-up, commands need a chip select falling edge first.
`timescale 1ns/100ps
module qpp_top #(
    parameter int unsigned DATA_W = qpp_pkg::BYTE_W
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic [3:0] LANE_I,
    output logic [3:0] LANE_O,
    output logic [3:0] LANE_OE_O,
    input wire logic QUAD_LANE_ENABLE_I,
    input wire logic STATUS_PROTECT_UPPER_I,
    input wire logic STATUS_PROTECT_LOWER_I,
    input wire logic [1:0] READ_MODE_I,
    input wire logic READ_ACTIVE_I,
    input wire logic [DATA_W-1:0] TX_DATA_I,
    input wire logic STATUS_WRITE_REQ_I,
    output logic STATUS_WRITE_OK_O,
    output logic [DATA_W-1:0] RX_DATA_O,
    output logic RX_VALID_O,
    output logic PAUSED_O,
    output logic ARMED_O
);
    // link-side pause tracking: pause pin is async to the serial clock, so it is
    // evaluated on its own edges gated by the clock level
    logic paused_lk;
    logic pause_pin_en;
    assign pause_pin_en = ~QUAD_LANE_ENABLE_I;
    always_ff @(negedge LANE_I[3] or posedge CS_N_I) begin
        if (CS_N_I) begin
            paused_lk <= 1'b0;
        end else if (pause_pin_en && !SCK_I) begin
            paused_lk <= 1'b1;
        end
    end
    logic resume_tog;
    always_ff @(posedge LANE_I[3] or posedge CS_N_I) begin
        if (CS_N_I) begin
            resume_tog <= 1'b0;
        end else if (pause_pin_en && !SCK_I) begin
            resume_tog <= ~resume_tog;
        end
    end
    logic resume_seen;
    logic paused_eff;
    always_ff @(negedge LANE_I[3] or posedge CS_N_I) begin
        if (CS_N_I) begin
            resume_seen <= 1'b0;
        end else if (pause_pin_en && !SCK_I) begin
            resume_seen <= resume_tog;
        end
    end
    assign paused_eff = paused_lk && (resume_seen == resume_tog);
    logic [1:0] lk_mode;
    logic [DATA_W-1:0] lk_rx;
    logic lk_tog;
    logic [3:0] lk_lanes;
    logic [2:0] lk_cnt;
    assign lk_mode = READ_MODE_I;
    qpp_shift #(.DATA_W(DATA_W)) u_shift (
        .sck_i(SCK_I),
        .cs_n_i(CS_N_I),
        .paused_i(paused_eff),
        .mode_i(lk_mode),
        .lane_in_i(LANE_I),
        .tx_data_i(TX_DATA_I),
        .rx_data_o(lk_rx),
        .rx_tog_o(lk_tog),
        .lane_out_o(lk_lanes),
        .bit_cnt_o(lk_cnt)
    );
    // system-side synchronisers for pins
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] next_s1;
    logic [2:0] next_s2;
    logic tog_d;
    logic next_tog_d;
    logic armed;
    logic next_armed;
    logic cs_d;
    logic next_cs_d;
    logic [DATA_W-1:0] rx_hold;
    logic [DATA_W-1:0] next_rx_hold;
    logic rx_valid;
    logic next_rx_valid;
    logic wr_ok;
    logic next_wr_ok;
    logic [3:0] lane_o;
    logic [3:0] next_lane_o;
    logic [3:0] lane_oe;
    logic [3:0] next_lane_oe;
    logic prot_pin_active;
    always_comb begin
        next_s1 = {CS_N_I, lk_tog, paused_eff};
        next_s2 = s1;
        next_cs_d = s2[2];
        next_tog_d = s2[1];
        next_armed = armed;
        if (cs_d && !s2[2]) begin
            next_armed = 1'b1;
        end
        next_rx_valid = 1'b0;
        next_rx_hold = rx_hold;
        // data word stable: it changed a full sync delay before the toggle is seen
        if ((s2[1] != tog_d) && armed && !s2[2]) begin
            next_rx_valid = 1'b1;
            next_rx_hold = lk_rx;
        end
        prot_pin_active = (QUAD_LANE_ENABLE_I == 1'b0)
            && (STATUS_PROTECT_UPPER_I == qpp_pkg::PROT_UPPER_NEEDED)
            && (STATUS_PROTECT_LOWER_I == qpp_pkg::PROT_LOWER_NEEDED);
        next_wr_ok = STATUS_WRITE_REQ_I && armed && !(prot_pin_active && !LANE_I[2]);
        // pin outputs are the link flops re-registered on the system clock; data launch edge is owned by the link
        next_lane_o = lk_lanes;
        next_lane_oe = qpp_pkg::LANE_OE_NONE;
        if (!CS_N_I && !paused_eff && READ_ACTIVE_I && armed) begin
            case (READ_MODE_I)
                qpp_pkg::MODE_DUAL: next_lane_oe = 4'h3;
                qpp_pkg::MODE_QUAD: next_lane_oe = QUAD_LANE_ENABLE_I ? 4'hF : 4'h0;
                default: next_lane_oe = 4'h2;
            endcase
        end
        if (CS_N_I) begin
            next_lane_oe = qpp_pkg::LANE_OE_NONE;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            s1 <= 3'h7;
            s2 <= 3'h7;
            cs_d <= 1'b1;
            tog_d <= 1'b0;
            armed <= 1'b0;
            rx_hold <= '0;
            rx_valid <= 1'b0;
            wr_ok <= 1'b0;
            lane_o <= 4'h0;
            lane_oe <= 4'h0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            cs_d <= next_cs_d;
            tog_d <= next_tog_d;
            armed <= next_armed;
            rx_hold <= next_rx_hold;
            rx_valid <= next_rx_valid;
            wr_ok <= next_wr_ok;
            lane_o <= next_lane_o;
            lane_oe <= next_lane_oe;
        end
    end
    assign LANE_O = lane_o;
    assign LANE_OE_O = lane_oe;
    assign RX_DATA_O = rx_hold;
    assign RX_VALID_O = rx_valid;
    assign STATUS_WRITE_OK_O = wr_ok;
    assign PAUSED_O = s2[0];
    assign ARMED_O = armed;

    AST_FLOAT_DESELECT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        CS_N_I |=> (LANE_OE_O == 4'h0)) else $error("lanes driven while deselected");
    AST_PROTECT_REFUSE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (prot_pin_active && !LANE_I[2]) |=> !STATUS_WRITE_OK_O)
        else $error("status write passed while protected");
    AST_NO_ARM_NO_RX: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !armed |=> !RX_VALID_O) else $error("data accepted before select edge");
    AST_DUAL_LANES: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!CS_N_I && !paused_eff && READ_ACTIVE_I && armed && READ_MODE_I == 2'h1)
        |=> (LANE_OE_O == 4'h3)) else $error("dual read lanes wrong");
    AST_PAUSE_FLOAT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        paused_eff |=> (LANE_OE_O == 4'h0)) else $error("driving while paused");
    AST_QUAD_NO_PAUSE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (QUAD_LANE_ENABLE_I && !CS_N_I && !paused_eff) [*3] |-> !PAUSED_O)
        else $error("pause seen in quad mode");
    AST_PROTECT_QUAD_OFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        QUAD_LANE_ENABLE_I |-> !prot_pin_active) else $error("protect in quad");
    AST_ARM_ON_SELECT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (cs_d && !s2[2]) |=> armed) else $error("select edge did not arm");
endmodule // qpp_top

// >>> test/qpp_host.sv
// host controller model: drives select, serial clock and all four lane pins
// assumes the serial clock stands low between transfers, as in mode 0
`timescale 1ns/100ps
module qpp_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] lane_o,
    input wire logic [3:0] lane_i
);
    logic [3:0] lanes = 4'hF;
    assign lane_o = lanes;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // select moves only with the clock low
    task automatic select(input logic on);
        cs_n_o = ~on;
        #32;
    endtask
    // pause pin moves only with the clock low
    task automatic pause_pin(input logic lvl);
        lanes[3] = lvl;
        #16;
    endtask
    // one 64 ns clock; data set while low, taken on the rise
    task automatic cycle(input logic d0, output logic [3:0] at_high, output logic [3:0] at_low);
        lanes[0] = d0;
        #16 sck_o = 1'b1;
        #31 at_high = lane_i;
        #1 sck_o = 1'b0;
        #16 at_low = lane_i;
    endtask
endmodule // qpp_host

// >>> test/qpp_top_test.sv
// self-checking bench for the quad-lane pin front end
// assumes the host model owns the serial side; lane pins sampled late in each phase
`timescale 1ns/100ps
module qpp_top_test;
    logic CLK_I, RST_N_I, SCK_I, CS_N_I, QUAD_LANE_ENABLE_I, READ_ACTIVE_I, STATUS_WRITE_REQ_I;
    logic STATUS_PROTECT_UPPER_I, STATUS_PROTECT_LOWER_I, STATUS_WRITE_OK_O;
    logic RX_VALID_O, PAUSED_O, ARMED_O;
    logic [1:0] READ_MODE_I;
    logic [3:0] LANE_I, LANE_O, LANE_OE_O, hi, lo, prev;
    logic [7:0] TX_DATA_I, RX_DATA_O, rx_seen, v;
    int bad_count = 0;
    int checks_done = 0;
    int rx_n = 0;
    logic [4:0] prot [4] = '{5'h04, 5'h07, 5'h15, 5'h0D};
    qpp_top u_qpp_top (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I),
        .LANE_I(LANE_I), .LANE_O(LANE_O), .LANE_OE_O(LANE_OE_O),
        .QUAD_LANE_ENABLE_I(QUAD_LANE_ENABLE_I), .STATUS_PROTECT_UPPER_I(STATUS_PROTECT_UPPER_I),
        .STATUS_PROTECT_LOWER_I(STATUS_PROTECT_LOWER_I), .READ_MODE_I(READ_MODE_I),
        .READ_ACTIVE_I(READ_ACTIVE_I), .TX_DATA_I(TX_DATA_I),
        .STATUS_WRITE_REQ_I(STATUS_WRITE_REQ_I), .STATUS_WRITE_OK_O(STATUS_WRITE_OK_O),
        .RX_DATA_O(RX_DATA_O), .RX_VALID_O(RX_VALID_O), .PAUSED_O(PAUSED_O), .ARMED_O(ARMED_O));
    qpp_host u_qpp_host (.sck_o(SCK_I), .cs_n_o(CS_N_I), .lane_o(LANE_I), .lane_i(LANE_O));
    initial begin
        CLK_I = 1'b0;
        forever #2.5 CLK_I = ~CLK_I;
    end
    // the byte pulse lasts one cycle, so catch it here rather than in a task
    always @(posedge CLK_I) begin
        if (RX_VALID_O === 1'b1) begin
            rx_n <= rx_n + 1;
            rx_seen <= RX_DATA_O;
        end
    end
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic send(input logic [7:0] b, input int pause_at);
        int n0 = rx_n;
        int k;
        for (int i = 7; i >= 0; i--) begin
            if (i == pause_at) begin
                u_qpp_host.pause_pin(1'b0);
                step(6);
                cmp("paused", 8'h01, {7'h00, PAUSED_O});
                cmp("oe while paused", 8'h00, {4'h0, LANE_OE_O});
                u_qpp_host.cycle(~b[i], hi, lo);
                u_qpp_host.pause_pin(1'b1);
                step(6);
                cmp("resumed", 8'h00, {7'h00, PAUSED_O});
            end
            u_qpp_host.cycle(b[i], hi, lo);
        end
        for (k = 0; k < 20 && rx_n == n0; k++) step(1);
        if (k == 20) begin
            bad_count++;
            end_of_test();
        end
        cmp("rx byte", b, rx_seen);
    endtask
    function automatic logic [3:0] oe_for(input logic [1:0] m);
        return (m == qpp_pkg::MODE_SINGLE) ? 4'h2 : (m == qpp_pkg::MODE_DUAL) ? 4'h3 : 4'hF;
    endfunction
    task automatic read(input logic [1:0] m, input logic [7:0] b);
        logic [3:0] oe = oe_for(m);
        logic [7:0] acc = 8'h00;
        int w = (m == qpp_pkg::MODE_QUAD) ? 4 : (m == qpp_pkg::MODE_DUAL) ? 2 : 1;
        READ_MODE_I = m;
        TX_DATA_I = b;
        READ_ACTIVE_I = 1'b1;
        u_qpp_host.select(1'b1);
        for (int c = 0; c < 8 / w; c++) begin
            // host lanes zero and one, all four in quad, show a changing pattern, never the last level
            if (w == 4) u_qpp_host.lanes[3:1] = ~u_qpp_host.lanes[3:1];
            else u_qpp_host.lanes[1] = ~u_qpp_host.lanes[1];
            u_qpp_host.cycle(~u_qpp_host.lanes[0], hi, lo);
            if (c > 0) cmp("lanes before fall", {4'h0, prev & oe}, {4'h0, hi & oe});
            prev = lo;
            acc = (w == 4) ? {acc[3:0], lo} : (w == 2) ? {acc[5:0], lo[1:0]} : {acc[6:0], lo[1]};
            cmp("read oe", {4'h0, oe}, {4'h0, LANE_OE_O});
        end
        cmp("read byte", b, acc);
        u_qpp_host.select(1'b0);
        READ_ACTIVE_I = 1'b0;
        u_qpp_host.lanes = 4'hF;
        step(4);
        cmp("oe deselected", 8'h00, {4'h0, LANE_OE_O});
        cmp("no pause", 8'h00, {7'h00, PAUSED_O});
    endtask
    initial begin
        RST_N_I = 1'b0;
        QUAD_LANE_ENABLE_I = 1'b0;
        STATUS_PROTECT_UPPER_I = 1'b0;
        STATUS_PROTECT_LOWER_I = 1'b1;
        READ_MODE_I = qpp_pkg::MODE_SINGLE;
        READ_ACTIVE_I = 1'b0;
        TX_DATA_I = 8'h00;
        STATUS_WRITE_REQ_I = 1'b0;
        void'($urandom(32'hC9F9));
        step(10);
        RST_N_I = 1'b1;
        step(4);
        cmp("armed at reset", 8'h00, {7'h00, ARMED_O});
        u_qpp_host.pause_pin(1'b0);
        step(6);
        cmp("pause deselected", 8'h00, {7'h00, PAUSED_O});
        u_qpp_host.pause_pin(1'b1);
        u_qpp_host.select(1'b1);
        step(6);
        cmp("armed", 8'h01, {7'h00, ARMED_O});
        send(8'h80, -1);
        for (int i = 0; i < 6; i++) send(8'($urandom), (i < 3) ? 2 * i + 1 : -1);
        u_qpp_host.select(1'b0);
        $display("write and pause tests done");
        for (int i = 0; i < 3; i++) begin
            QUAD_LANE_ENABLE_I = (i == 2);
            step(4);
            read(2'(i), (i == 0) ? 8'hA5 : 8'($urandom));
        end
        QUAD_LANE_ENABLE_I = 1'b0;
        $display("read tests done");
        for (int i = 0; i < 8; i++) begin
            STATUS_WRITE_REQ_I = (i < 4) ? 1'b1 : 1'($urandom);
            QUAD_LANE_ENABLE_I = prot[i % 4][4];
            STATUS_PROTECT_UPPER_I = prot[i % 4][3];
            STATUS_PROTECT_LOWER_I = prot[i % 4][2];
            u_qpp_host.lanes[2] = prot[i % 4][1];
            step(6);
            cmp("status write ok", {7'h00, prot[i % 4][0] & STATUS_WRITE_REQ_I},
                {7'h00, STATUS_WRITE_OK_O});
        end
        $display("protect tests done");
        end_of_test();
    end
    initial begin
        #2000000;
        bad_count++;
        end_of_test();
    end
endmodule // qpp_top_test
